// File: hdl/edge_delay_filter.sv
`timescale 1ns/100ps
module edge_delay_filter
   import rail_enable_pkg::*;
#(
   parameter int UNIT_CYCLES_P = UNIT_CYCLES
) (
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   edge_delay_if.filter dly
);
   logic [5:0]  units_needed;
   logic [5:0]  units_q;
   logic [31:0] tick_q;
   logic        out_q;
   logic        pending;

   // Delay in 2 ms units for the edge now waiting
   function automatic logic [5:0] rise_units(input logic [2:0] c);
      case (c)
         3'h0: rise_units = 6'h00;
         3'h1: rise_units = 6'h01;
         3'h2: rise_units = 6'h02;
         3'h3: rise_units = 6'h04;
         3'h4: rise_units = 6'h08;
         3'h5: rise_units = 6'h0C;
         3'h6: rise_units = 6'h10;
         default: rise_units = 6'h20;
      endcase
   endfunction

   function automatic logic [5:0] fall_units(input logic [2:0] c);
      case (c)
         3'h0: fall_units = 6'h00;
         3'h1: fall_units = 6'h01;
         3'h2: fall_units = 6'h02;
         3'h3: fall_units = 6'h04;
         3'h4: fall_units = 6'h08;
         3'h5: fall_units = 6'h0C;
         3'h6: fall_units = 6'h10;
         default: fall_units = 6'h20;
      endcase
   endfunction

   assign pending = dly.raw_enable != out_q;
   assign units_needed = dly.raw_enable ? rise_units(dly.rise_code)
                                        : fall_units(dly.fall_code);

   // Timebase counts whole 2 ms units while an edge waits
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !pending) begin
         tick_q  <= '0;
         units_q <= '0;
      end else if (tick_q == 32'(UNIT_CYCLES_P - 1)) begin
         tick_q  <= '0;
         units_q <= units_q + 6'h01;
      end else begin
         tick_q  <= tick_q + 32'h1;
      end
   end

   // Edge passes once the programmed delay has run out
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         out_q <= 1'b0;
      end else if (pending && units_q >= units_needed) begin
         out_q <= dly.raw_enable;
      end
   end

   assign dly.delayed_enable = out_q;
endmodule : edge_delay_filter

// File: hdl/edge_delay_if.sv
`timescale 1ns/100ps
interface edge_delay_if;
   logic       raw_enable;
   logic [2:0] rise_code;
   logic [2:0] fall_code;
   logic       delayed_enable;
   modport owner  (output raw_enable, output rise_code, output fall_code,
                   input delayed_enable);
   modport filter (input raw_enable, input rise_code, input fall_code,
                   output delayed_enable);
endinterface : edge_delay_if

// File: hdl/rail_enable_gating_logic.sv
// Operation
// - Mask bits 0 to 4 drop step-down rails one to five power-good when 1.
// - Mask bits 7, 6, 5 drop second LDO, first A switch, step-down six.
// - Bit 1 of the second register drops first B switch power-good when 1.
// - Bit 0 of the second register drops third LDO power-good when 1.
// - Bits 6:5 of the second register drive the threshold code out.
// - Source code picks control input 1, 2, 5, 4, 3 or 6.
// - Source code 101 needs inputs 3 and 4 both high.
// - Source code 111 enables with no input.
// - Falling delay codes give 0, 2, 4, 8, 16, 24, 32 and 64 ms.
// - Rising delay codes give 0, 2, 4, 8, 16, 24, 32 and 64 ms.
// - Each delay need only be within ten percent of nominal.
`timescale 1ns/100ps
module rail_enable_gating_logic
   import rail_enable_pkg::*;
#(
   parameter int UNIT_CYCLES_P = UNIT_CYCLES
) (
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_write,
   output logic [7:0]      reg_rdata,
   input  wire logic [5:0] control_input,
   input  wire logic [5:0] step_down_power_good,
   input  wire logic       first_a_switch_power_good,
   input  wire logic       first_b_switch_power_good,
   input  wire logic       second_ldo_power_good,
   input  wire logic       third_ldo_power_good,
   output logic [1:0]      pair_good_threshold_select,
   output logic            switch_ldo_pair_enable
);
   logic [7:0]     masks_q;
   logic [7:0]     pin_thresh_q;
   logic [7:0]     delays_q;
   logic [7:0]     rdata_d;
   logic [7:0]     rdata_q;
   logic           selected;
   logic           goods_ok;
   logic           enable_q;
   logic [7:0]     good_vec;
   logic [7:0]     good_pass;
   source_select_t source;

   edge_delay_if dly ();

   // Register writes
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         masks_q      <= MASKS_RESET;
         pin_thresh_q <= PIN_THRESH_RESET;
         delays_q     <= EDGE_DELAYS_RESET;
      end else if (reg_write) begin
         case (reg_addr)
            MASKS_OFFSET:       masks_q      <= reg_wdata;
            PIN_THRESH_OFFSET:  pin_thresh_q <= reg_wdata;
            EDGE_DELAYS_OFFSET: delays_q     <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Register reads, unmapped offsets read zero
   always_comb begin
      case (reg_addr)
         MASKS_OFFSET:       rdata_d = masks_q;
         PIN_THRESH_OFFSET:  rdata_d = pin_thresh_q;
         EDGE_DELAYS_OFFSET: rdata_d = delays_q;
         default:            rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   // Threshold code to the comparator
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pair_good_threshold_select <= 2'h0;
      end else begin
         pair_good_threshold_select <=
            pin_thresh_q[THRESHOLD_SELECT_LSB +: 2];
      end
   end

   // Enable source multiplexer
   assign source = source_select_t'(pin_thresh_q[SOURCE_SELECT_LSB +: 3]);

   always_comb begin
      case (source)
         SRC_INPUT_ONE:   selected = control_input[0];
         SRC_INPUT_TWO:   selected = control_input[1];
         SRC_INPUT_FIVE:  selected = control_input[4];
         SRC_INPUT_FOUR:  selected = control_input[3];
         SRC_INPUT_THREE: selected = control_input[2];
         SRC_THREE_FOUR:  selected = control_input[2] & control_input[3];
         SRC_INPUT_SIX:   selected = control_input[5];
         SRC_ALWAYS_ON:   selected = 1'b1;
         default:         selected = 1'b0;
      endcase
   end

   assign dly.raw_enable = selected;
   assign dly.rise_code  = delays_q[RISE_DELAY_LSB +: 3];
   assign dly.fall_code  = delays_q[FALL_DELAY_LSB +: 3];

   edge_delay_filter #(
      .UNIT_CYCLES_P (UNIT_CYCLES_P)
   ) u_delay (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .dly     (dly.filter)
   );

   // Power-good masking, a set mask bit forces that term true
   assign good_vec = {second_ldo_power_good, first_a_switch_power_good,
                      step_down_power_good};
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_mask
         assign good_pass[g] = good_vec[g] | masks_q[g];
      end
   endgenerate

   assign goods_ok = &good_pass
      & (first_b_switch_power_good
         | pin_thresh_q[MASK_FIRST_B_SWITCH_BIT])
      & (third_ldo_power_good | pin_thresh_q[MASK_THIRD_LDO_BIT]);

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         enable_q <= 1'b0;
      end else begin
         enable_q <= dly.delayed_enable & goods_ok;
      end
   end

   assign switch_ldo_pair_enable = enable_q;
endmodule : rail_enable_gating_logic

// File: hdl/rail_enable_pkg.sv
package rail_enable_pkg;

   // Register offsets
   localparam logic [7:0] MASKS_OFFSET         = 8'h25;
   localparam logic [7:0] PIN_THRESH_OFFSET    = 8'h26;
   localparam logic [7:0] EDGE_DELAYS_OFFSET   = 8'h27;

   // Reset values
   localparam logic [7:0] MASKS_RESET          = 8'h00;
   localparam logic [7:0] PIN_THRESH_RESET     = 8'h00;
   localparam logic [7:0] EDGE_DELAYS_RESET    = 8'h00;

   // Field positions
   localparam int MASK_STEP_DOWN_LSB            = 0;
   localparam int MASK_STEP_DOWN_SIX_BIT        = 5;
   localparam int MASK_FIRST_A_SWITCH_BIT       = 6;
   localparam int MASK_SECOND_LDO_BIT           = 7;
   localparam int MASK_THIRD_LDO_BIT            = 0;
   localparam int MASK_FIRST_B_SWITCH_BIT       = 1;
   localparam int SOURCE_SELECT_LSB             = 2;
   localparam int THRESHOLD_SELECT_LSB          = 5;
   localparam int RISE_DELAY_LSB                = 0;
   localparam int FALL_DELAY_LSB                = 3;

   // Enable source codes
   typedef enum logic [2:0] {
      SRC_INPUT_ONE   = 3'h0,
      SRC_INPUT_TWO   = 3'h1,
      SRC_INPUT_FIVE  = 3'h2,
      SRC_INPUT_FOUR  = 3'h3,
      SRC_INPUT_THREE = 3'h4,
      SRC_THREE_FOUR  = 3'h5,
      SRC_INPUT_SIX   = 3'h6,
      SRC_ALWAYS_ON   = 3'h7
   } source_select_t;

   // Timing
   localparam int CLOCK_HZ        = 25_000_000;
   localparam int DELAY_UNIT_MS   = 2;
   localparam int UNIT_CYCLES     = CLOCK_HZ / 1000 * DELAY_UNIT_MS;

endpackage

// File: testbench/rail_enable_gating_logic_test.sv
`timescale 1ns/100ps
module rail_enable_gating_logic_test;
   import rail_enable_pkg::*;
   localparam int U = 4;
   logic       sys_clk = 0, sys_rst = 1, reg_write = 0, en;
   logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
   logic [5:0] ci;
   logic [9:0] g;
   logic [1:0] thr;
   int         err_count = 0, n_tests = 0, t;
   always #20 sys_clk = ~sys_clk;
   rail_pins_model pins (.sys_clk(sys_clk), .control_input(ci), .goods(g));
   rail_enable_gating_logic #(.UNIT_CYCLES_P(U)) dut (.sys_clk(sys_clk),
      .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_rdata(reg_rdata), .control_input(ci),
      .step_down_power_good(g[5:0]), .first_a_switch_power_good(g[6]),
      .first_b_switch_power_good(g[8]), .second_ldo_power_good(g[7]),
      .third_ldo_power_good(g[9]), .pair_good_threshold_select(thr),
      .switch_ldo_pair_enable(en));
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      n_tests++;
      if (s !== e) begin
         err_count++;
         $display("[FAIL] %0t saw %h expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1;
      @(posedge sys_clk);
      reg_write <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      @(posedge sys_clk);
      #1 chk(reg_rdata, e);
   endtask
   task automatic settle(input logic e);
      repeat (8) @(posedge sys_clk);
      #1 chk(en, e);
   endtask
   // Edges from a pin change until the enable reaches the level
   task automatic meas(input logic [5:0] c, input logic l, input int n);
      pins.drive(c, 10'h3FF);
      t = 0;
      while (en !== l && t < 500) begin
         @(posedge sys_clk);
         #1 t++;
      end
      chk(t >= n && t <= n + 6, 1);
   endtask
   initial begin
      #2_000_000;
      err_count++;
      end_of_test();
   end
   initial begin
      int         b [8] = '{0, 1, 4, 3, 2, 9, 5, 9};
      int         u [8] = '{0, 1, 2, 4, 8, 12, 16, 32};
      logic [5:0] c;
      logic [9:0] m;
      repeat (10) @(posedge sys_clk);
      sys_rst <= 0;
      for (int i = 0; i < 4; i++) rd(8'(8'h25 + i), 8'h00);
      for (int i = 0; i < 3; i++) begin
         wr(8'(8'h25 + i), 8'hFF);
         rd(8'(8'h25 + i), 8'hFF);
      end
      wr(8'h28, 8'hFF);
      rd(8'h28, 8'h00);
      for (int i = 0; i < 4; i++) begin
         wr(8'h26, 8'(i << 5));
         repeat (2) @(posedge sys_clk);
         #1 chk(thr, 8'(i));
      end
      wr(8'h25, 8'h00);
      wr(8'h27, 8'h00);
      for (int k = 0; k < 7; k++) begin
         if (k == 5) continue;
         c = 6'h01 << b[k];
         wr(8'h26, 8'(k << 2));
         pins.drive(c, 10'h3FF);
         settle(1);
         pins.drive(~c, 10'h3FF);
         settle(0);
      end
      wr(8'h26, 8'h14);
      pins.drive(6'h04, 10'h3FF);
      settle(0);
      pins.drive(6'h08, 10'h3FF);
      settle(0);
      pins.drive(6'h0C, 10'h3FF);
      settle(1);
      wr(8'h26, 8'h1C);
      pins.drive(6'h00, 10'h3FF);
      settle(1);
      for (int i = 0; i < 10; i++) begin
         m = 10'h001 << i;
         pins.drive(6'h00, ~m);
         settle(0);
         wr(8'h25, m[7:0]);
         wr(8'h26, {5'h07, m[8], m[9]});
         settle(1);
         wr(8'h25, 8'h00);
         wr(8'h26, 8'h1C);
      end
      wr(8'h26, 8'h00);
      for (int k = 0; k < 8; k++) begin
         wr(8'h27, 8'({k[2:0], k[2:0]}));
         meas(6'h01, 1, u[k] * U + 1);
         meas(6'h00, 0, u[k] * U + 1);
      end
      end_of_test();
   end
endmodule // rail_enable_gating_logic_test

// File: testbench/rail_enable_sva.sv
`timescale 1ns/100ps
module rail_enable_sva
   import rail_enable_pkg::*;
#(
   parameter int UNIT_CYCLES_P = UNIT_CYCLES
) (
   input wire logic       sys_clk,
   input wire logic       sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_write,
   input wire logic [7:0] reg_rdata,
   input wire logic [5:0] control_input,
   input wire logic [5:0] step_down_power_good,
   input wire logic       first_a_switch_power_good,
   input wire logic       first_b_switch_power_good,
   input wire logic       second_ldo_power_good,
   input wire logic       third_ldo_power_good,
   input wire logic [1:0] pair_good_threshold_select,
   input wire logic       switch_ldo_pair_enable
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   logic [7:0]  m_q, p_q, d_q, src;
   logic [15:0] hi_q, lo_q;
   logic        sel, ok;
   int          rc, fc;
   function automatic int cyc(input logic [2:0] c);
      int u [8] = '{0, 1, 2, 4, 8, 12, 16, 32};
      return u[c] * UNIT_CYCLES_P;
   endfunction
   assign src = {1'b1, control_input[5], &control_input[3:2],
      control_input[2], control_input[3], control_input[4],
      control_input[1:0]};
   assign sel = src[p_q[4:2]];
   assign ok = &({second_ldo_power_good, first_a_switch_power_good,
      step_down_power_good} | m_q) & (first_b_switch_power_good | p_q[1])
      & (third_ldo_power_good | p_q[0]);
   assign rc = cyc(d_q[2:0]);
   assign fc = cyc(d_q[5:3]);
   // Shadow copies of the three registers
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         m_q <= 8'h00;
         p_q <= 8'h00;
         d_q <= 8'h00;
      end else if (reg_write) begin
         if (reg_addr == MASKS_OFFSET) m_q <= reg_wdata;
         if (reg_addr == PIN_THRESH_OFFSET) p_q <= reg_wdata;
         if (reg_addr == EDGE_DELAYS_OFFSET) d_q <= reg_wdata;
      end
   end
   // Run lengths of the selected input, saturating
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !sel) hi_q <= 16'h0000;
      else if (~&hi_q) hi_q <= hi_q + 16'h0001;
      if (sys_rst || sel) lo_q <= 16'h0000;
      else if (~&lo_q) lo_q <= lo_q + 16'h0001;
   end
   thresh_copy_a: assert property (
      reg_write && reg_addr == PIN_THRESH_OFFSET
      |-> ##2 pair_good_threshold_select == $past(reg_wdata[6:5], 2))
      else $error("threshold output differs from written code");
   unmapped_zero_a: assert property (!(reg_addr inside {[8'h25:8'h27]})
      |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   good_gating_a: assert property (!ok |=> !switch_ldo_pair_enable)
      else $error("enable high with an unmasked rail not good");
   both_inputs_a: assert property (
      (p_q[4:2] == 3'h5 && fc == 0 && !sel)[*3]
      |=> !switch_ldo_pair_enable) else $error("enable without both inputs");
   rise_early_a: assert property (
      $rose(switch_ldo_pair_enable) |-> hi_q >= rc)
      else $error("enable rose before its delay");
   rise_late_a: assert property (hi_q == rc + 6 && ok && $past(ok)
      |-> switch_ldo_pair_enable) else $error("enable rose too late");
   fall_early_a: assert property (
      $fell(switch_ldo_pair_enable) && $past(ok)
      |-> lo_q >= fc) else $error("enable fell before its delay");
   fall_late_a: assert property (lo_q == fc + 6 |-> !switch_ldo_pair_enable)
      else $error("enable fell too late");
endmodule // rail_enable_sva
bind rail_enable_gating_logic rail_enable_sva
   #(.UNIT_CYCLES_P(UNIT_CYCLES_P)) chk (.*);

// File: testbench/rail_pins_model.sv
`timescale 1ns/100ps
module rail_pins_model (
   input wire logic  sys_clk,
   output logic [5:0] control_input,
   output logic [9:0] goods
);
   initial control_input = 6'h00;
   initial goods = 10'h3FF;
   // Pins change just after a rising edge
   task automatic drive(input logic [5:0] c, input logic [9:0] g);
      @(posedge sys_clk);
      control_input <= c;
      goods <= g;
   endtask
endmodule // rail_pins_model
